/* File: shared/ack_tag_regs_pkg.sv */
/*
 * Package for the per-port link maintenance reply and acknowledge-tag register bank.
 * Assumes an APB slave with 32-bit data and bit 0 being the word's most significant bit.
 */
package ack_tag_regs_pkg;
    localparam int NumPorts = 16;
    localparam int PortStride = 32'h20;
    localparam logic [11:0] RequestOffset = 12'h040;
    localparam logic [11:0] ReplyOffset = 12'h044;
    localparam logic [11:0] TagStatusOffset = 12'h048;
    localparam logic [11:0] LastReplyOffset = 12'h224;
    localparam logic [11:0] LastTagStatusOffset = 12'h228;
    // Bit positions given as documented bit numbers, bit 0 = msb
    localparam int ValidBitNum = 0;
    localparam int DiscardBitNum = 0;
    localparam int ReplyTagLsbNum = 27;
    localparam int LinkStateLsbNum = 31;
    localparam int RxTagLsbNum = 7;
    localparam int BitmapLsbNum = 23;
    localparam int TxTagLsbNum = 31;
    localparam int CommandLsbNum = 31;
    localparam logic [2:0] ReplyTagReset = 3'h0;
    localparam logic [3:0] LinkStateReset = 4'h0;
    localparam logic [2:0] TagReset = 3'h0;
    localparam logic [7:0] BitmapReset = 8'h00;
    localparam logic [2:0] CommandReset = 3'h0;

    // Link-response as delivered by the port's receiver
    typedef struct packed {
        logic valid;
        logic [2:0] replyTagState;
        logic [3:0] linkState;
    } link_reply_s;

    // Link-request handed to the port's transmitter
    typedef struct packed {
        logic valid;
        logic [2:0] command;
    } link_request_s;
endpackage

/* File: src/link_maint_reply_tag_state_regs.sv */
/*
 * Register bank for link maintenance replies and acknowledge-tag bookkeeping, all ports.
 * Assumes an APB master on clock, and port logic that reports sent requests, replies,
 * accepted and transmitted packets and acknowledges with one-cycle pulses per port.
 */
// Operation
// - One reply register per port, at 0x44 for port 0 through 0x224.
// - Reading the reply register returns status of the latest link-response.
// - Writes to the reply register are ignored.
// - Valid flag sets when an expected link-response arrives.
// - Valid flag sets once a no-reply link-request has been sent.
// - A read of the reply register clears the valid flag, unless the flag sets in the same cycle.
// - Bits 25-27 hold the reply tag state, reset 0.
// - Bits 28-31 hold the link state, reset 0.
// - One tag status register per port, at 0x48 through 0x228.
// - Tag status read shows inbound and outbound tag state together.
// - Writing one to bit 0 discards all unacknowledged packets.
// - The discard bit holds no state and reads as zero.
// - Bits 5-7 show the next expected inbound tag, reset 0.
// - Bits 16-23 mark each tag sent but not yet acknowledged.
// - Bitmap msb stands for tag 0, lsb for tag 7.
// - Bits 29-31 hold the next outbound tag.
// - Writing the outbound tag restarts retransmission from that tag.
// - Writing the request register sends a link-request with command bits 29-31.
`timescale 1ns/10ps
`default_nettype none
module link_maint_reply_tag_state_regs (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [15:0] requestSent,
    input wire logic [15:0] requestExpectsReply,
    input wire ack_tag_regs_pkg::link_reply_s [15:0] linkReply,
    input wire logic [15:0] rxPacketAccepted,
    input wire logic [15:0] txPacketSent,
    input wire logic [15:0] txAckReceived,
    input wire logic [47:0] txAckTag,
    output ack_tag_regs_pkg::link_request_s [15:0] linkRequest,
    output logic [15:0] discardUnackedPackets,
    output logic [15:0] retransmitStart,
    output logic [47:0] txNextTag
);
    // ****************************************
    // Bus decode
    // ****************************************
    logic access;
    logic [3:0] portSel;
    logic [4:0] portOffset;
    logic inRange;
    logic isReq;
    logic isReply;
    logic isTag;
    logic [31:0] nxt_prdata;
    assign access = psel && penable && !pready;
    assign portSel = 4'(paddr[9:5] - 5'h2);
    assign portOffset = paddr[4:0];
    assign inRange = paddr >= ack_tag_regs_pkg::RequestOffset && paddr <= ack_tag_regs_pkg::LastTagStatusOffset;
    assign isReq = inRange && portOffset == ack_tag_regs_pkg::RequestOffset[4:0];
    assign isReply = inRange && portOffset == ack_tag_regs_pkg::ReplyOffset[4:0];
    assign isTag = inRange && portOffset == ack_tag_regs_pkg::TagStatusOffset[4:0];

    // ****************************************
    // Per-port state
    // ****************************************
    logic [15:0] replyValid_ff;
    logic [2:0] replyTag_ff [16];
    logic [3:0] linkState_ff [16];
    logic [2:0] rxTag_ff [16];
    logic [2:0] txTag_ff [16];
    logic [7:0] bitmap_ff [16];
    logic [2:0] command_ff [16];

    for (genvar p = 0; p < 16; p++) begin : g_port
        logic hit;
        logic wrReq;
        logic wrTag;
        logic rdReply;
        logic [7:0] setMask;
        logic [7:0] clrMask;
        assign hit = access && portSel == 4'(p);
        assign wrReq = hit && pwrite && isReq;
        assign wrTag = hit && pwrite && isTag;
        assign rdReply = hit && !pwrite && isReply;
        // Tag t maps to bitmap bit 7-t
        assign setMask = txPacketSent[p] ? (8'h80 >> txTag_ff[p]) : 8'h00;
        assign clrMask = txAckReceived[p] ? (8'h80 >> txAckTag[3*p +: 3]) : 8'h00;

        always_ff @(posedge clock) begin
            if (!rst_n) begin
                replyValid_ff[p] <= 1'b0;
            end else if ((linkReply[p].valid && requestExpectsReply[p])
                    || (requestSent[p] && !requestExpectsReply[p])) begin
                replyValid_ff[p] <= 1'b1;
            end else if (rdReply) begin
                replyValid_ff[p] <= 1'b0;
            end
        end

        always_ff @(posedge clock) begin
            if (!rst_n) begin
                replyTag_ff[p] <= ack_tag_regs_pkg::ReplyTagReset;
                linkState_ff[p] <= ack_tag_regs_pkg::LinkStateReset;
            end else if (linkReply[p].valid) begin
                replyTag_ff[p] <= linkReply[p].replyTagState;
                linkState_ff[p] <= linkReply[p].linkState;
            end
        end

        always_ff @(posedge clock) begin
            if (!rst_n) begin
                rxTag_ff[p] <= ack_tag_regs_pkg::TagReset;
            end else if (rxPacketAccepted[p]) begin
                rxTag_ff[p] <= rxTag_ff[p] + 3'h1;
            end
        end

        always_ff @(posedge clock) begin
            if (!rst_n) begin
                txTag_ff[p] <= ack_tag_regs_pkg::TagReset;
            end else if (wrTag) begin
                txTag_ff[p] <= pwdata[31 - ack_tag_regs_pkg::TxTagLsbNum +: 3];
            end else if (txPacketSent[p]) begin
                txTag_ff[p] <= txTag_ff[p] + 3'h1;
            end
        end

        always_ff @(posedge clock) begin
            if (!rst_n) begin
                bitmap_ff[p] <= ack_tag_regs_pkg::BitmapReset;
            end else if (wrTag && pwdata[31 - ack_tag_regs_pkg::DiscardBitNum]) begin
                bitmap_ff[p] <= setMask;
            end else begin
                bitmap_ff[p] <= (bitmap_ff[p] & ~clrMask) | setMask;
            end
        end

        always_ff @(posedge clock) begin
            if (!rst_n) begin
                discardUnackedPackets[p] <= 1'b0;
                retransmitStart[p] <= 1'b0;
                linkRequest[p] <= '0;
                command_ff[p] <= ack_tag_regs_pkg::CommandReset;
            end else begin
                discardUnackedPackets[p] <= wrTag && pwdata[31 - ack_tag_regs_pkg::DiscardBitNum];
                retransmitStart[p] <= wrTag;
                linkRequest[p].valid <= wrReq;
                linkRequest[p].command <= pwdata[31 - ack_tag_regs_pkg::CommandLsbNum +: 3];
                if (wrReq) begin
                    command_ff[p] <= pwdata[31 - ack_tag_regs_pkg::CommandLsbNum +: 3];
                end
            end
        end

        assign txNextTag[3*p +: 3] = txTag_ff[p];
    end

    // ****************************************
    // Read data and APB answer
    // ****************************************
    always_comb begin
        nxt_prdata = 32'h0;
        if (isReq) begin
            nxt_prdata[31 - ack_tag_regs_pkg::CommandLsbNum +: 3] = command_ff[portSel];
        end else if (isReply) begin
            nxt_prdata[31 - ack_tag_regs_pkg::ValidBitNum] = replyValid_ff[portSel];
            nxt_prdata[31 - ack_tag_regs_pkg::ReplyTagLsbNum +: 3] = replyTag_ff[portSel];
            nxt_prdata[31 - ack_tag_regs_pkg::LinkStateLsbNum +: 4] = linkState_ff[portSel];
        end else if (isTag) begin
            nxt_prdata[31 - ack_tag_regs_pkg::RxTagLsbNum +: 3] = rxTag_ff[portSel];
            nxt_prdata[31 - ack_tag_regs_pkg::BitmapLsbNum +: 8] = bitmap_ff[portSel];
            nxt_prdata[31 - ack_tag_regs_pkg::TxTagLsbNum +: 3] = txTag_ff[portSel];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= access;
            pslverr <= access && !(isReq || isReply || isTag);
            prdata <= (access && !pwrite) ? nxt_prdata : 32'h0;
        end
    end
endmodule
`default_nettype wire

/* File: verification/ack_tag_regs_monitor.sv */
/* Checker for the tag register bank, port 0. Assumes binding to the top module. */
`timescale 1ns/10ps
`default_nettype none
module ack_tag_regs_monitor (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic [15:0] txPacketSent,
    input wire ack_tag_regs_pkg::link_request_s [15:0] linkRequest,
    input wire logic [15:0] discardUnackedPackets,
    input wire logic [15:0] retransmitStart,
    input wire logic [47:0] txNextTag
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic take;
    logic tagWr;
    assign take = psel & penable & ~pready;
    assign tagWr = take & pwrite & (paddr == 12'h048);
    request_send_a: assert property (take && pwrite && paddr == 12'h040
        |=> linkRequest[0] == {1'b1, $past(pwdata[2:0])}) else $error("request not sent");
    discard_pulse_a: assert property (tagWr |=> discardUnackedPackets[0] == $past(pwdata[31]))
        else $error("discard pulse wrong");
    idle_pulse_a: assert property (!tagWr |=> !discardUnackedPackets[0] && !retransmitStart[0])
        else $error("stray pulse");
    retransmit_a: assert property (tagWr |=> retransmitStart[0] && txNextTag[2:0] == $past(pwdata[2:0]))
        else $error("tx tag write lost");
    tx_advance_a: assert property (txPacketSent[0] && !tagWr
        |=> txNextTag[2:0] == $past(txNextTag[2:0]) + 3'h1) else $error("tx tag not advanced");
    tx_hold_a: assert property (!txPacketSent[0] && !tagWr |=> $stable(txNextTag[2:0]))
        else $error("tx tag moved");
    tag_read_a: assert property (take && !pwrite && paddr == 12'h048
        |=> pready && (prdata & 32'hf8ff_00f8) == 32'h0) else $error("tag reserved bits set");
    reply_read_a: assert property (take && !pwrite && paddr == 12'h044
        |=> pready && prdata[30:7] == 24'h0) else $error("reply reserved bits set");
endmodule
bind link_maint_reply_tag_state_regs ack_tag_regs_monitor ack_tag_regs_monitor_inst (.clock, .rst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .txPacketSent, .linkRequest, .discardUnackedPackets,
    .retransmitStart, .txNextTag);
`default_nettype wire

/* File: verification/link_partner_model.sv */
/* Link partner of port 0: answers link-requests. Assumes replyDelay of at least one. */
`timescale 1ns/10ps
`default_nettype none
module link_partner_model #(parameter logic [2:0] NoReplyCmd = 3'h3) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] replyDelay,
    input wire ack_tag_regs_pkg::link_request_s [15:0] linkRequest,
    output logic [15:0] requestSent,
    output logic [15:0] requestExpectsReply,
    output ack_tag_regs_pkg::link_reply_s [15:0] linkReply
);
    logic [7:0] wait_ff;
    logic [2:0] cmd_ff;
    always_ff @(posedge clock) begin
        requestSent <= 16'h0;
        linkReply[0].valid <= 1'b0;
        linkReply[0].replyTagState <= ~linkReply[0].replyTagState;
        linkReply[0].linkState <= ~linkReply[0].linkState;
        if (!rst_n) begin
            linkReply <= '0;
            requestExpectsReply <= 16'h0;
            wait_ff <= 8'h0;
            cmd_ff <= 3'h0;
        end else if (linkRequest[0].valid) begin
            requestSent[0] <= 1'b1;
            requestExpectsReply[0] <= linkRequest[0].command != NoReplyCmd;
            cmd_ff <= linkRequest[0].command;
            wait_ff <= (linkRequest[0].command != NoReplyCmd) ? replyDelay : 8'h0;
        end else if (wait_ff == 8'h1) begin
            wait_ff <= 8'h0;
            linkReply[0] <= {1'b1, cmd_ff, 1'b1, cmd_ff};
        end else if (wait_ff != 8'h0) begin
            wait_ff <= wait_ff - 8'h1;
        end
    end
endmodule
`default_nettype wire

/* File: verification/tb_link_maint_reply_tag_state_regs.sv */
/* Testbench for the tag register bank. Assumes the partner model on port 0. */
`timescale 1ns/10ps
`default_nettype none
module tb_link_maint_reply_tag_state_regs;
    logic clock, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [15:0] requestSent, requestExpectsReply, rxPacketAccepted, txPacketSent, txAckReceived;
    logic [15:0] discardUnackedPackets, retransmitStart;
    logic [47:0] txAckTag, txNextTag;
    logic [7:0] replyDelay;
    ack_tag_regs_pkg::link_reply_s [15:0] linkReply;
    ack_tag_regs_pkg::link_request_s [15:0] linkRequest;
    int errCount, checked;
    link_maint_reply_tag_state_regs link_maint_reply_tag_state_regs_inst (.clock, .rst_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pready, .prdata, .pslverr, .requestSent, .requestExpectsReply, .linkReply,
        .rxPacketAccepted, .txPacketSent, .txAckReceived, .txAckTag, .linkRequest, .discardUnackedPackets,
        .retransmitStart, .txNextTag);
    link_partner_model link_partner_model_inst (.clock, .rst_n, .replyDelay, .linkRequest, .requestSent,
        .requestExpectsReply, .linkReply);
    task stop_test;
        $display("Mismatches %0d of %0d checks", errCount, checked);
        if (errCount == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errCount++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic rdy;
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clock);
        penable <= 1'b1;
        // Sample the answer settled mid-cycle, release after the edge that sees it
        do begin
            @(negedge clock);
            rdy = pready;
            rdata = prdata;
            err = pslverr;
            @(posedge clock);
        end while (rdy !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask
    task poll(input logic [31:0] exp);
        for (int i = 0; i < 40; i++) begin
            apb(1'b0, 12'h044, 32'h0);
            if (rdata[31] === 1'b1) break;
        end
        chk(rdata, exp);
    endtask
    task pkt(input logic [2:0] k);
        @(posedge clock);
        {rxPacketAccepted[0], txPacketSent[0], txAckReceived[0]} <= k;
        @(posedge clock);
        {rxPacketAccepted[0], txPacketSent[0], txAckReceived[0]} <= 3'h0;
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        #50000;
        errCount++;
        stop_test();
    end
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {rxPacketAccepted, txPacketSent, txAckReceived, txAckTag} = '0;
        replyDelay = 8'h1;
        errCount = 0;
        checked = 0;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        rd(12'h044, 32'h0);
        rd(12'h048, 32'h0);
        rd(12'h224, 32'h0);
        rd(12'h228, 32'h0);
        apb(1'b0, 12'h04c, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, 12'h044, 32'hffff_ffff);
        rd(12'h044, 32'h0);
        apb(1'b1, 12'h040, 32'h5);
        poll(32'h8000_005d);
        rd(12'h044, 32'h0000_005d);
        replyDelay <= 8'hc;
        apb(1'b1, 12'h040, 32'h6);
        poll(32'h8000_006e);
        apb(1'b1, 12'h040, 32'h3);
        poll(32'h8000_006e);
        rd(12'h040, 32'h3);
        repeat (9) pkt(3'h4);
        repeat (3) pkt(3'h2);
        rd(12'h048, 32'h0100_e003);
        txAckTag <= 48'h1;
        pkt(3'h1);
        rd(12'h048, 32'h0100_a003);
        apb(1'b1, 12'h048, 32'h6);
        rd(12'h048, 32'h0100_a006);
        apb(1'b1, 12'h048, 32'h8000_0006);
        rd(12'h048, 32'h0100_0006);
        apb(1'b1, 12'h228, 32'h5);
        chk({29'h0, txNextTag[47:45]}, 32'h5);
        stop_test();
    end
endmodule
`default_nettype wire
